// *** timer_pwm.sv ***
// Summary of operation
// - Selector 5, 6, 7, 14, 15 counts BOTTOM to TOP, then restarts at BOTTOM.
// - Single slope TOP is 0x00FF/0x01FF/0x03FF, capture or channel A; clears after TOP.
// - Single slope non-inverting sets on match, clears at TOP to BOTTOM; inverting swaps.
// - Action two is non-inverted PWM, three inverted, in both slope kinds.
// - Single slope overflow flag at TOP, plus flag of the register holding TOP.
// - Every PWM mode flags a channel match when count equals its compare value.
// - Fixed TOP masks compare bits above the resolution when written.
// - Capture TOP acts at once; written below count, counter wraps through 0xFFFF.
// - Single slope compare writes buffer; copied at TOP with clear and overflow.
// - Single slope compare 0 gives one-cycle spike; compare TOP gives constant level.
// - Selector 15, channel A action 1 toggles on match for 50% duty.
// - Selector 1, 2, 3, 10, 11 counts up to TOP and down, TOP held once.
// - Dual slope TOP fixed, capture or channel A; reaching TOP reverses direction.
// - Dual slope non-inverting clears on up match, sets on down match; inverting swaps.
// - Dual slope overflow flag is set at BOTTOM.
// - Dual slope buffers copy at TOP, with the flag of the TOP register.
// - Dual slope compare BOTTOM holds low, TOP holds high; inverted is opposite.
// - Selector 11, channel A action 1 toggles on each match, 50% duty.
// - With TOP below a compare value that channel never matches.
// - Counter advances only on the prescaled timer tick.
// - Compare level reaches the pin only while its direction bit is output.
// - Action zero leaves the internal compare output unchanged on a match.
// - Reset clears the internal compare output state to zero.
// - Nonzero action replaces the general port level with the compare output.
//
// Added by the designer: the plain strobed port and the placing of the registers.
`timescale 1ns/1ps
`default_nettype none

module timer_pwm
   import timer_pwm_pkg::*;
(
   // Clock and reset
   input  wire logic                              clock,
   input  wire logic                              nrst,
   // Register port
   input  wire logic [timer_pwm_pkg::ADDR_W-1:0]  reg_addr,
   input  wire logic [timer_pwm_pkg::DATA_W-1:0]  reg_wdata,
   input  wire logic                              reg_write,
   input  wire logic                              reg_read,
   output logic      [timer_pwm_pkg::DATA_W-1:0]  reg_rdata,
   // Prescaled timer clock enable
   input  wire logic                              timer_tick,
   // Compare output pins
   output logic                                   chan_a_pin_out,
   output logic                                   chan_a_pin_oe,
   output logic                                   chan_b_pin_out,
   output logic                                   chan_b_pin_oe
);
   import timer_pwm_pkg::*;

   // ****************************************************************
   // Registers and decode
   // ****************************************************************
   logic [CTRL_W-1:0] ctrl;
   logic [CNT_W-1:0]  count_value;
   logic [CNT_W-1:0]  capture_top_reg;
   logic [FLAG_W-1:0] flags;
   dir_type           direction;
   logic [CNT_W-1:0]  cmp_buf [2];
   logic [CNT_W-1:0]  compare_value [2];
   logic [1:0]        compare_output;
   logic [1:0]        pin_out;
   logic [1:0]        pin_oe;

   logic [3:0]        waveform_mode_sel;
   logic [CNT_W-1:0]  top_val;
   logic              at_top;
   logic              at_bottom;
   logic              single_mode;
   logic              dual_mode;
   logic              update_point;
   logic [1:0]        match;
   logic [FLAG_W-1:0] flag_set;
   logic [FLAG_W-1:0] flag_clr;

   assign waveform_mode_sel = ctrl[CTRL_MODE_LSB +: 4];
   assign single_mode       = is_single(waveform_mode_sel);
   assign dual_mode         = is_dual(waveform_mode_sel);
   assign top_val           = top_of(waveform_mode_sel, capture_top_reg, compare_value[0]);
   assign at_top            = (count_value == top_val);
   assign at_bottom         = (count_value == BOTTOM);

   // Buffer copy point: TOP in both slope kinds
   assign update_point = timer_tick && at_top &&
                         (single_mode || (dual_mode && direction == COUNT_UP));

   // ****************************************************************
   // Control and capture registers
   // ****************************************************************

   // Control register
   always_ff @(posedge clock or negedge nrst) begin
      if (!nrst) begin
         ctrl <= CTRL_RST;
      end else if (reg_write && reg_addr == REG_CTRL) begin
         ctrl <= reg_wdata[CTRL_W-1:0];
      end
   end

   // Capture TOP register is unbuffered and acts at once
   always_ff @(posedge clock or negedge nrst) begin
      if (!nrst) begin
         capture_top_reg <= CAPT_RST;
      end else if (reg_write && reg_addr == REG_CAPT) begin
         capture_top_reg <= reg_wdata[CNT_W-1:0];
      end
   end

   // ****************************************************************
   // Counter
   // ****************************************************************

   // Count sequence per slope kind, only on the timer tick
   always_ff @(posedge clock or negedge nrst) begin
      if (!nrst) begin
         count_value <= CNT_RST;
         direction   <= COUNT_UP;
      end else if (reg_write && reg_addr == REG_COUNT) begin
         count_value <= reg_wdata[CNT_W-1:0];
      end else if (timer_tick) begin
         if (single_mode) begin
            direction <= COUNT_UP;
            if (at_top) begin
               count_value <= BOTTOM;
            end else begin
               count_value <= count_value + 16'h0001;  // wraps through MAX
            end
         end else if (dual_mode) begin
            if (direction == COUNT_UP) begin
               if (at_top) begin
                  direction   <= COUNT_DOWN;
                  count_value <= count_value - 16'h0001;
               end else begin
                  count_value <= count_value + 16'h0001;
               end
            end else begin
               if (at_bottom) begin
                  direction   <= COUNT_UP;
                  count_value <= count_value + 16'h0001;
               end else begin
                  count_value <= count_value - 16'h0001;
               end
            end
         end else begin
            direction   <= COUNT_UP;
            count_value <= count_value + 16'h0001;
         end
      end
   end

   // ****************************************************************
   // Flags
   // ****************************************************************

   // Hardware events that raise the flags
   always_comb begin
      flag_set = FLAGS_RST;
      if (single_mode) begin
         flag_set[FLAG_OVF] = timer_tick && at_top;
      end else if (dual_mode) begin
         flag_set[FLAG_OVF] = timer_tick && at_bottom && direction == COUNT_DOWN;
      end else begin
         flag_set[FLAG_OVF] = timer_tick && count_value == MAX;
      end
      flag_set[FLAG_MATCH_LSB]     = match[0] ||
                                     (update_point && (waveform_mode_sel == MODE_FAST_CMPA ||
                                                       waveform_mode_sel == MODE_PC_CMPA));
      flag_set[FLAG_MATCH_LSB + 1] = match[1];
      flag_set[FLAG_CAPT]          = update_point && (waveform_mode_sel == MODE_FAST_CAPT ||
                                                      waveform_mode_sel == MODE_PC_CAPT);
   end

   assign flag_clr = (reg_write && reg_addr == REG_FLAGS) ? reg_wdata[FLAG_W-1:0] : FLAGS_RST;

   // Write one to clear; a set in the same cycle wins
   always_ff @(posedge clock or negedge nrst) begin
      if (!nrst) begin
         flags <= FLAGS_RST;
      end else begin
         flags <= (flags & ~flag_clr) | flag_set;
      end
   end

   // ****************************************************************
   // Compare channels
   // ****************************************************************
   genvar ch;
   generate
      for (ch = 0; ch < 2; ch++) begin : g_chan
         logic [1:0] action;
         logic       rising;
         logic       toggle_ok;

         assign action    = ctrl[CTRL_ACT_LSB + 2*ch +: 2];
         assign match[ch] = timer_tick && (count_value == compare_value[ch]);
         // At BOTTOM a match counts as rising, at TOP as falling
         assign rising    = at_bottom ? 1'b1 : (at_top ? 1'b0 : (direction == COUNT_UP));
         assign toggle_ok = (ch == 0) && (waveform_mode_sel == MODE_FAST_CMPA ||
                                          waveform_mode_sel == MODE_PC_CMPA);

         // Buffered write path, masked under a fixed TOP
         always_ff @(posedge clock or negedge nrst) begin
            if (!nrst) begin
               cmp_buf[ch] <= CNT_RST;
            end else if (reg_write && reg_addr == (ch == 0 ? REG_CMP_A : REG_CMP_B)) begin
               if (is_fixed(waveform_mode_sel)) begin
                  cmp_buf[ch] <= reg_wdata[CNT_W-1:0] & top_val;
               end else begin
                  cmp_buf[ch] <= reg_wdata[CNT_W-1:0];
               end
            end
         end

         // Active compare value: copied at TOP in PWM modes, else follows
         always_ff @(posedge clock or negedge nrst) begin
            if (!nrst) begin
               compare_value[ch] <= CNT_RST;
            end else if (!(single_mode || dual_mode)) begin
               compare_value[ch] <= cmp_buf[ch];
            end else if (update_point) begin
               compare_value[ch] <= cmp_buf[ch];
            end
         end

         // Internal compare output state
         always_ff @(posedge clock or negedge nrst) begin
            if (!nrst) begin
               compare_output[ch] <= 1'b0;
            end else if (single_mode) begin
               case (action)
                  ACT_NON_INV: begin
                     if (match[ch]) begin
                        compare_output[ch] <= 1'b1;
                     end else if (timer_tick && at_top) begin
                        compare_output[ch] <= 1'b0;
                     end
                  end
                  ACT_INV: begin
                     if (match[ch]) begin
                        compare_output[ch] <= 1'b0;
                     end else if (timer_tick && at_top) begin
                        compare_output[ch] <= 1'b1;
                     end
                  end
                  ACT_TOGGLE: begin
                     if (match[ch] && toggle_ok) begin
                        compare_output[ch] <= ~compare_output[ch];
                     end
                  end
                  default: begin
                     compare_output[ch] <= compare_output[ch];
                  end
               endcase
            end else if (dual_mode) begin
               case (action)
                  ACT_NON_INV: begin
                     if (match[ch]) begin
                        compare_output[ch] <= ~rising;
                     end
                  end
                  ACT_INV: begin
                     if (match[ch]) begin
                        compare_output[ch] <= rising;
                     end
                  end
                  ACT_TOGGLE: begin
                     if (match[ch] && toggle_ok) begin
                        compare_output[ch] <= ~compare_output[ch];
                     end
                  end
                  default: begin
                     compare_output[ch] <= compare_output[ch];
                  end
               endcase
            end
         end

         // Pin level and driver enable
         always_ff @(posedge clock or negedge nrst) begin
            if (!nrst) begin
               pin_out[ch] <= 1'b0;
               pin_oe[ch]  <= 1'b0;
            end else begin
               if (action != ACT_NONE) begin
                  pin_out[ch] <= compare_output[ch];
               end else begin
                  pin_out[ch] <= ctrl[CTRL_PORT_LSB + ch];
               end
               pin_oe[ch] <= ctrl[CTRL_DIR_LSB + ch];
            end
         end
      end
   endgenerate

   assign chan_a_pin_out = pin_out[0];
   assign chan_a_pin_oe  = pin_oe[0];
   assign chan_b_pin_out = pin_out[1];
   assign chan_b_pin_oe  = pin_oe[1];

   // ****************************************************************
   // Read data
   // ****************************************************************

   // Read data stand only in the cycle after the read strobe
   always_ff @(posedge clock or negedge nrst) begin
      if (!nrst) begin
         reg_rdata <= '0;
      end else if (reg_read) begin
         case (reg_addr)
            REG_CTRL:   reg_rdata <= {20'h00000, ctrl};
            REG_COUNT:  reg_rdata <= {16'h0000, count_value};
            REG_CMP_A:  reg_rdata <= {16'h0000, cmp_buf[0]};
            REG_CMP_B:  reg_rdata <= {16'h0000, cmp_buf[1]};
            REG_CAPT:   reg_rdata <= {16'h0000, capture_top_reg};
            REG_FLAGS:  reg_rdata <= {28'h0000000, flags};
            REG_STATUS: reg_rdata <= {29'h00000000, compare_output, direction};
            default:    reg_rdata <= '0;
         endcase
      end else begin
         reg_rdata <= '0;
      end
   end

endmodule : timer_pwm

`default_nettype wire

// *** timer_pwm_pkg.sv ***
package timer_pwm_pkg;

   // ****************************************************************
   // Bus and counter widths
   // ****************************************************************
   localparam int ADDR_W = 8;
   localparam int DATA_W = 32;
   localparam int CNT_W  = 16;

   // ****************************************************************
   // Register byte offsets
   // ****************************************************************
   localparam logic [7:0] REG_CTRL   = 8'h00;
   localparam logic [7:0] REG_COUNT  = 8'h04;
   localparam logic [7:0] REG_CMP_A  = 8'h08;
   localparam logic [7:0] REG_CMP_B  = 8'h0C;
   localparam logic [7:0] REG_CAPT   = 8'h10;
   localparam logic [7:0] REG_FLAGS  = 8'h14;
   localparam logic [7:0] REG_STATUS = 8'h18;

   // ****************************************************************
   // Field positions
   // ****************************************************************
   localparam int CTRL_MODE_LSB  = 0;   // 4 bits waveform_mode_sel
   localparam int CTRL_ACT_LSB   = 4;   // 2 bits per channel, A then B
   localparam int CTRL_DIR_LSB   = 8;   // pin_dir_bit, A then B
   localparam int CTRL_PORT_LSB  = 10;  // general port level, A then B
   localparam int CTRL_W         = 12;
   localparam int FLAG_OVF       = 0;
   localparam int FLAG_MATCH_LSB = 1;   // match A, match B
   localparam int FLAG_CAPT      = 3;
   localparam int FLAG_W         = 4;

   // ****************************************************************
   // Reset values and counter limits
   // ****************************************************************
   localparam logic [CTRL_W-1:0] CTRL_RST  = 12'h000;
   localparam logic [CNT_W-1:0]  CNT_RST   = 16'h0000;
   localparam logic [CNT_W-1:0]  CAPT_RST  = 16'h0000;
   localparam logic [FLAG_W-1:0] FLAGS_RST = 4'h0;
   localparam logic [CNT_W-1:0]  BOTTOM    = 16'h0000;
   localparam logic [CNT_W-1:0]  MAX       = 16'hFFFF;
   localparam logic [CNT_W-1:0]  TOP_8BIT  = 16'h00FF;
   localparam logic [CNT_W-1:0]  TOP_9BIT  = 16'h01FF;
   localparam logic [CNT_W-1:0]  TOP_10BIT = 16'h03FF;

   // ****************************************************************
   // Waveform modes and output actions
   // ****************************************************************
   localparam logic [3:0] MODE_PC8       = 4'h1;
   localparam logic [3:0] MODE_PC9       = 4'h2;
   localparam logic [3:0] MODE_PC10      = 4'h3;
   localparam logic [3:0] MODE_FAST8     = 4'h5;
   localparam logic [3:0] MODE_FAST9     = 4'h6;
   localparam logic [3:0] MODE_FAST10    = 4'h7;
   localparam logic [3:0] MODE_PC_CAPT   = 4'hA;
   localparam logic [3:0] MODE_PC_CMPA   = 4'hB;
   localparam logic [3:0] MODE_FAST_CAPT = 4'hE;
   localparam logic [3:0] MODE_FAST_CMPA = 4'hF;

   localparam logic [1:0] ACT_NONE    = 2'h0;
   localparam logic [1:0] ACT_TOGGLE  = 2'h1;
   localparam logic [1:0] ACT_NON_INV = 2'h2;
   localparam logic [1:0] ACT_INV     = 2'h3;

   typedef enum logic [0:0] {
      COUNT_UP   = 1'b0,
      COUNT_DOWN = 1'b1
   } dir_type;

   // ****************************************************************
   // Mode decoding
   // ****************************************************************
   function automatic logic is_single(input logic [3:0] mode);
      is_single = (mode == MODE_FAST8) || (mode == MODE_FAST9) || (mode == MODE_FAST10) ||
                  (mode == MODE_FAST_CAPT) || (mode == MODE_FAST_CMPA);
   endfunction : is_single

   function automatic logic is_dual(input logic [3:0] mode);
      is_dual = (mode == MODE_PC8) || (mode == MODE_PC9) || (mode == MODE_PC10) ||
                (mode == MODE_PC_CAPT) || (mode == MODE_PC_CMPA);
   endfunction : is_dual

   function automatic logic [CNT_W-1:0] top_of(input logic [3:0]       mode,
                                                input logic [CNT_W-1:0] capt,
                                                input logic [CNT_W-1:0] cmpa);
      case (mode)
         MODE_PC8, MODE_FAST8:         top_of = TOP_8BIT;
         MODE_PC9, MODE_FAST9:         top_of = TOP_9BIT;
         MODE_PC10, MODE_FAST10:       top_of = TOP_10BIT;
         MODE_PC_CAPT, MODE_FAST_CAPT: top_of = capt;
         MODE_PC_CMPA, MODE_FAST_CMPA: top_of = cmpa;
         default:                      top_of = MAX;
      endcase
   endfunction : top_of

   function automatic logic is_fixed(input logic [3:0] mode);
      is_fixed = (mode == MODE_PC8) || (mode == MODE_PC9) || (mode == MODE_PC10) ||
                 (mode == MODE_FAST8) || (mode == MODE_FAST9) || (mode == MODE_FAST10);
   endfunction : is_fixed

endpackage : timer_pwm_pkg

// *** timer_pwm_chk_sva.sv ***
`timescale 1ns/1ps
`default_nettype none
// ****************************************************************
// Port checker for the PWM timer
// ****************************************************************
module timer_pwm_chk
   import timer_pwm_pkg::*;
(
   // Clock and reset
   input wire logic                             clock,
   input wire logic                             nrst,
   // Register port
   input wire logic [timer_pwm_pkg::ADDR_W-1:0] reg_addr,
   input wire logic [timer_pwm_pkg::DATA_W-1:0] reg_wdata,
   input wire logic                             reg_write,
   input wire logic                             reg_read,
   input wire logic [timer_pwm_pkg::DATA_W-1:0] reg_rdata,
   // Timer tick and pins
   input wire logic                             timer_tick,
   input wire logic                             chan_a_pin_out,
   input wire logic                             chan_a_pin_oe,
   input wire logic                             chan_b_pin_out,
   input wire logic                             chan_b_pin_oe
);
   default clocking cb @(posedge clock); endclocking
   default disable iff (!nrst);
   // Control register write seen on the port
   logic ctrl_wr;
   assign ctrl_wr = reg_write && (reg_addr == REG_CTRL);
   chk_rdata_idle: assert property (!reg_read |=> reg_rdata == '0)
      else $error("read data not zero outside a read answer");
   chk_flags_upper: assert property (reg_read && reg_addr == REG_FLAGS |=> reg_rdata[31:FLAG_W] == '0)
      else $error("flag word upper bits not zero");
   chk_reset_clear: assert property ($rose(nrst) |-> !chan_a_pin_out && !chan_b_pin_out && !chan_a_pin_oe)
      else $error("pins not cleared by reset");
   chk_oe_dir_a: assert property (ctrl_wr ##1 !ctrl_wr |=> chan_a_pin_oe == $past(reg_wdata[8], 2))
      else $error("channel A enable does not follow its direction bit");
   chk_oe_dir_b: assert property (ctrl_wr ##1 !ctrl_wr |=> chan_b_pin_oe == $past(reg_wdata[9], 2))
      else $error("channel B enable does not follow its direction bit");
   chk_port_level_a: assert property (ctrl_wr && reg_wdata[5:4] == ACT_NONE ##1 !ctrl_wr ##1 !ctrl_wr
      |-> chan_a_pin_out == $past(reg_wdata[10], 2))
      else $error("channel A pin does not show the port level");
   chk_quiet_a: assert property ((!timer_tick && !reg_write) [*4] |-> $stable(chan_a_pin_out))
      else $error("channel A pin moved without a tick");
   chk_quiet_b: assert property ((!timer_tick && !reg_write) [*4] |-> $stable(chan_b_pin_out))
      else $error("channel B pin moved without a tick");
   // Main scenarios reached
   cov_toggle: cover property (ctrl_wr && reg_wdata[5:4] == ACT_TOGGLE);
   cov_rise: cover property ($rose(chan_a_pin_out));
   cov_flags: cover property (reg_read && reg_addr == REG_FLAGS);
endmodule : timer_pwm_chk
bind timer_pwm timer_pwm_chk u_chk (.clock(clock), .nrst(nrst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
   .reg_write(reg_write), .reg_read(reg_read), .reg_rdata(reg_rdata), .timer_tick(timer_tick),
   .chan_a_pin_out(chan_a_pin_out), .chan_a_pin_oe(chan_a_pin_oe), .chan_b_pin_out(chan_b_pin_out),
   .chan_b_pin_oe(chan_b_pin_oe));
`default_nettype wire

// *** pwm_load.sv ***
`timescale 1ns/1ps
`default_nettype none
// ****************************************************************
// External load on a compare output pin
// ****************************************************************
module pwm_load (
   input  wire logic        clock,
   input  wire logic        drive_level,
   input  wire logic        drive_en,
   input  wire logic        measure,
   output wire logic        line,
   output var  logic [31:0] high_cnt
);
   // Pull-down holds the line low while the pin driver is off
   assign line = drive_en ? drive_level : 1'b0;
   // Count high samples while measuring
   always @(posedge clock) begin
      if (!measure) high_cnt <= 32'h0;
      else if (line) high_cnt <= high_cnt + 32'h1;
   end
endmodule : pwm_load
`default_nettype wire

// *** tb_timer16_fast_and_phase_pwm.sv ***
`timescale 1ns/1ps
`default_nettype none
module tb_timer16_fast_and_phase_pwm
   import timer_pwm_pkg::*;
;
   typedef struct {logic [3:0] mode; logic [1:0] act; logic [15:0] top; logic [15:0] cmp; int win; int high;} row_type;
   logic              clock = 1'b0;
   logic              nrst, reg_write, reg_read, timer_tick, measure;
   logic [ADDR_W-1:0] reg_addr;
   logic [DATA_W-1:0] reg_wdata, reg_rdata, d;
   logic              a_out, a_oe, b_out, b_oe, a_line;
   logic [31:0]       high_cnt;
   int                error_cnt = 0;
   int                checked = 0;
   // Mode, action, TOP, compare A, window, high cycles in window; register TOP kept at 3 or more
   row_type rows [13] = '{'{4'hE,2'h2,16'h9,16'h3,20,12}, '{4'hE,2'h3,16'h9,16'h3,20,8}, '{4'hE,2'h2,16'h9,16'h0,20,18},
      '{4'hE,2'h2,16'h9,16'h9,20,20}, '{4'hE,2'h3,16'h9,16'h9,20,0}, '{4'hA,2'h2,16'h9,16'h3,36,12},
      '{4'hA,2'h3,16'h9,16'h3,36,24}, '{4'hA,2'h2,16'h9,16'h0,36,0}, '{4'hA,2'h2,16'h9,16'h9,36,36},
      '{4'hF,2'h1,16'h5,16'h5,24,12}, '{4'hB,2'h1,16'h5,16'h5,40,20}, '{4'h5,2'h2,16'h9,16'h1F80,256,127},
      '{4'h1,2'h2,16'h9,16'h1F80,510,256}};
   timer_pwm u_dut (.clock(clock), .nrst(nrst), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_write(reg_write),
      .reg_read(reg_read), .reg_rdata(reg_rdata), .timer_tick(timer_tick), .chan_a_pin_out(a_out),
      .chan_a_pin_oe(a_oe), .chan_b_pin_out(b_out), .chan_b_pin_oe(b_oe));
   pwm_load u_load (.clock(clock), .drive_level(a_out), .drive_en(a_oe), .measure(measure), .line(a_line),
      .high_cnt(high_cnt));
   always #50 clock = ~clock;
   // ****************************************************************
   // Bus and check tasks
   // ****************************************************************
   task automatic wr(input logic [7:0] a, input logic [31:0] v);
      @(posedge clock);
      reg_addr  <= a;
      reg_wdata <= v;
      reg_write <= 1'b1;
      @(posedge clock);
      reg_write <= 1'b0;
   endtask : wr
   task automatic rd(input logic [7:0] a, output logic [31:0] v);
      @(posedge clock);
      reg_addr <= a;
      reg_read <= 1'b1;
      @(posedge clock);
      reg_read <= 1'b0;
      // Read data stand in this cycle; take them at its closing edge
      @(posedge clock);
      v = reg_rdata;
   endtask : rd
   task automatic check_val(input logic [31:0] seen, input logic [31:0] exp);
      checked++;
      if (seen !== exp) begin
         error_cnt++;
         $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask : check_val
   task automatic finish_test();
      $display("checks %0d mismatches %0d", checked, error_cnt);
      if (error_cnt == 0 && checked > 0) $display("Run complete: PASS");
      else $display("Run complete: FAIL");
      $finish;
   endtask : finish_test
   // Watchdog well beyond the expected run of about 4000 cycles
   initial begin
      repeat (40000) @(posedge clock);
      error_cnt++;
      finish_test();
   end
   // ****************************************************************
   // Main sequence
   // ****************************************************************
   initial begin
      nrst = 1'b0;
      reg_addr = '0;
      reg_wdata = '0;
      reg_write = 1'b0;
      reg_read = 1'b0;
      timer_tick = 1'b0;
      measure = 1'b0;
      repeat (6) @(posedge clock);
      nrst <= 1'b1;
      repeat (2) @(posedge clock);
      timer_tick <= 1'b1;
      // Waveform table, channel A driven, duty measured by the load; TOP fixed only in the mode 5 and mode 1 rows
      foreach (rows[i]) begin
         wr(REG_CTRL, 32'h100 | 32'(rows[i].act) << 4 | 32'(rows[i].mode));
         wr(REG_CAPT, 32'(rows[i].top));
         wr(REG_CMP_A, 32'(rows[i].cmp));
         wr(REG_COUNT, 32'h0);
         repeat (2 * rows[i].win + 8) @(posedge clock);
         measure <= 1'b1;
         repeat (rows[i].win) @(posedge clock);
         measure <= 1'b0;
         @(posedge clock);
         check_val(high_cnt, 32'(rows[i].high));
         $display("row %0d done", i);
      end
      // Frozen counter, then wrap through MAX past a missed capture TOP
      timer_tick <= 1'b0;
      wr(REG_CTRL, 32'h12E);
      wr(REG_CAPT, 32'h9);
      wr(REG_COUNT, 32'hFFFE);
      repeat (5) @(posedge clock);
      rd(REG_COUNT, d);
      check_val(d, 32'hFFFE);
      repeat (3) begin
         @(posedge clock);
         timer_tick <= 1'b1;
         @(posedge clock);
         timer_tick <= 1'b0;
      end
      rd(REG_COUNT, d);
      check_val(d, 32'h1);
      wr(REG_FLAGS, 32'hF);
      rd(REG_FLAGS, d);
      check_val(d, 32'h0);
      wr(REG_CMP_A, 32'h3);
      wr(REG_CMP_B, 32'hFFF0);
      timer_tick <= 1'b1;
      repeat (13) @(posedge clock);
      timer_tick <= 1'b0;
      rd(REG_FLAGS, d);
      check_val(d, 32'hB);
      $display("wrap and flag test done");
      // Unmapped access and readback
      rd(8'h1C, d);
      check_val(d, 32'h0);
      wr(8'h1C, 32'hFFFFFFFF);
      rd(REG_CTRL, d);
      check_val(d, 32'h12E);
      // Driver off, then port level with no output action
      wr(REG_CTRL, 32'h02E);
      repeat (3) @(posedge clock);
      check_val({a_oe, a_line}, 32'h0);
      wr(REG_CTRL, 32'h500);
      repeat (3) @(posedge clock);
      check_val(a_line, 32'h1);
      // Action zero in a running PWM mode keeps the internal state; channel B shows its port level
      wr(REG_CTRL, 32'hF0E);
      timer_tick <= 1'b1;
      repeat (25) @(posedge clock);
      timer_tick <= 1'b0;
      rd(REG_STATUS, d);
      check_val(d, 32'h2);
      check_val({b_oe, b_out}, 32'h3);
      $display("pin test done");
      // Second reset in mid-run
      nrst <= 1'b0;
      repeat (6) @(posedge clock);
      nrst <= 1'b1;
      rd(REG_CTRL, d);
      check_val(d, 32'h0);
      rd(REG_COUNT, d);
      check_val(d, 32'h0);
      rd(REG_STATUS, d);
      check_val(d, 32'h0);
      check_val({a_oe, a_out}, 32'h0);
      $display("reset test done");
      finish_test();
   end
endmodule : tb_timer16_fast_and_phase_pwm
`default_nettype wire
